// ---- src/power_mode_controller.sv ----
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - Active: clocks run, peripherals follow enables
// - Idle bit halts core; interrupt/reset exits
// - Suspend/stop: core, irq, timers, oscillator off
// - Suspend on internal clock stops peripherals
// - Suspend bit; port match or comparator wakes
// - Stop bit halts clock, digital peripherals
// - Debug halt stalls core, timers, peripherals; ADC, oscillator and clock run
module power_mode_controller #(
    parameter int NPERIPH = 8
) (
    input  wire logic               SYS_CLK_IN,
    input  wire logic               RST_IN,
    input  wire logic [7:0]         ADDR_IN,
    input  wire logic [7:0]         WDATA_IN,
    input  wire logic               WR_IN,
    input  wire logic               RD_IN,
    output logic      [7:0]         RDATA_OUT,
    input  wire logic               IRQ_PENDING_IN,
    input  wire logic               DEBUG_HALT_IN,
    input  wire logic               PORT0_MATCH_IN,
    input  wire logic               PORT1_MATCH_IN,
    input  wire logic               CMP0_OUT_IN,
    output logic                    CORE_RUN_OUT,
    output logic                    OSC_RUN_OUT,
    output logic                    SYSTEM_CLOCK_RUN_OUT,
    output logic                    TIMERS_IRQ_RUN_OUT,
    output logic                    ADC_RUN_OUT,
    output logic      [NPERIPH-1:0] PERIPH_RUN_OUT,
    output logic      [1:0]         MODE_OUT
);
    // ==========================================================
    // Wake inputs from pins
    // ==========================================================
    logic [2:0]             pins_s;
    logic                   cmp0_en_r;
    pmc_pkg::wake_src_t     wake;

    pin_sync #(.WIDTH(3)) u_sync (
        .clk_in (SYS_CLK_IN),
        .rst_in (RST_IN),
        .d_in   ({PORT0_MATCH_IN, PORT1_MATCH_IN, CMP0_OUT_IN}),
        .q_out  (pins_s)
    );

    assign wake = '{port0_match:  pins_s[2],
                    port1_match:  pins_s[1],
                    cmp0_enabled: cmp0_en_r,
                    cmp0_out:     pins_s[0]};

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0]          pwr_ctrl_r;
    logic [7:0]          osc_ctrl_r;
    logic [NPERIPH-1:0]  periph_en_r;
    pmc_pkg::mode_code_t mode_r;
    pmc_pkg::mode_code_t mode_nxt;
    logic                wr_pwr;
    logic                wr_osc;
    logic                wr_per;
    logic                suspend_wake;
    logic                int_clk_src;
    logic [7:0]          rd_mux;

    assign wr_pwr = WR_IN && (ADDR_IN == pmc_pkg::ADDR_POWER_CTRL);
    assign wr_osc = WR_IN && (ADDR_IN == pmc_pkg::ADDR_OSC_CTRL);
    assign wr_per = WR_IN && (ADDR_IN == pmc_pkg::ADDR_PERIPH_EN);
    assign int_clk_src = ~osc_ctrl_r[pmc_pkg::CLKSRC_BIT];

    assign suspend_wake = wake.port0_match || wake.port1_match ||
                          (wake.cmp0_enabled && !wake.cmp0_out);

    // ==========================================================
    // Mode sequencing
    // ==========================================================
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            pmc_pkg::MODE_ACTIVE: begin
                // Stop outranks suspend, suspend outranks idle
                if (pwr_ctrl_r[pmc_pkg::STOP_BIT])
                    mode_nxt = pmc_pkg::MODE_STOP;
                else if (osc_ctrl_r[pmc_pkg::SUSPEND_BIT])
                    mode_nxt = pmc_pkg::MODE_SUSPEND;
                else if (pwr_ctrl_r[pmc_pkg::IDLE_BIT])
                    mode_nxt = pmc_pkg::MODE_IDLE;
            end
            pmc_pkg::MODE_IDLE: begin
                if (IRQ_PENDING_IN)
                    mode_nxt = pmc_pkg::MODE_ACTIVE;
            end
            pmc_pkg::MODE_SUSPEND: begin
                if (suspend_wake)
                    mode_nxt = pmc_pkg::MODE_ACTIVE;
            end
            pmc_pkg::MODE_STOP: mode_nxt = pmc_pkg::MODE_STOP;
            default: mode_nxt = pmc_pkg::MODE_ACTIVE;
        endcase
    end

    logic idle_exit;
    logic susp_exit;
    assign idle_exit = (mode_r == pmc_pkg::MODE_IDLE) && IRQ_PENDING_IN;
    assign susp_exit = (mode_r == pmc_pkg::MODE_SUSPEND) && suspend_wake;

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            mode_r      <= pmc_pkg::MODE_ACTIVE;
            pwr_ctrl_r  <= pmc_pkg::REG_RESET;
            osc_ctrl_r  <= pmc_pkg::REG_RESET;
            periph_en_r <= '0;
            cmp0_en_r   <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            if (wr_pwr)
                pwr_ctrl_r <= WDATA_IN;
            else if (idle_exit)
                pwr_ctrl_r[pmc_pkg::IDLE_BIT] <= 1'b0;
            if (wr_osc)
                osc_ctrl_r <= WDATA_IN;
            else if (susp_exit)
                osc_ctrl_r[pmc_pkg::SUSPEND_BIT] <= 1'b0;
            if (wr_per) begin
                periph_en_r <= WDATA_IN[NPERIPH-1:0];
                cmp0_en_r   <= WDATA_IN[pmc_pkg::CMP0_EN_BIT];
            end
        end
    end

    // ==========================================================
    // Gating
    // ==========================================================
    pmc_pkg::gate_t gate_nxt;
    logic           low_pwr;
    logic           periph_stop;
    assign low_pwr = (mode_nxt == pmc_pkg::MODE_SUSPEND) ||
                     (mode_nxt == pmc_pkg::MODE_STOP);
    // Peripherals lose their clock in stop, or in suspend on internal clock
    assign periph_stop = (mode_nxt == pmc_pkg::MODE_STOP) ||
                         ((mode_nxt == pmc_pkg::MODE_SUSPEND) && int_clk_src);

    always_comb begin
        gate_nxt.core_run       = (mode_nxt == pmc_pkg::MODE_ACTIVE) && !DEBUG_HALT_IN;
        gate_nxt.osc_run        = !low_pwr;
        gate_nxt.system_clock_run     = (mode_nxt != pmc_pkg::MODE_STOP) &&
                                  !((mode_nxt == pmc_pkg::MODE_SUSPEND) && int_clk_src);
        gate_nxt.timers_irq_run = !low_pwr && !DEBUG_HALT_IN;
        // ADC keeps running under debug halt; its analog state follows stop gating
        gate_nxt.adc_run        = !periph_stop;
        gate_nxt.periph_run     = (periph_stop || DEBUG_HALT_IN) ? 8'h00 :
                                  8'(periph_en_r);
    end

    assign rd_mux = (ADDR_IN == pmc_pkg::ADDR_POWER_CTRL) ? pwr_ctrl_r :
                    (ADDR_IN == pmc_pkg::ADDR_OSC_CTRL)   ? osc_ctrl_r :
                    (ADDR_IN == pmc_pkg::ADDR_PERIPH_EN)  ? {cmp0_en_r, 7'(periph_en_r)} :
                    (ADDR_IN == pmc_pkg::ADDR_MODE_STAT)  ? {6'h00, mode_r} : 8'h00;

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            CORE_RUN_OUT       <= 1'b1;
            OSC_RUN_OUT        <= 1'b1;
            SYSTEM_CLOCK_RUN_OUT     <= 1'b1;
            TIMERS_IRQ_RUN_OUT <= 1'b1;
            ADC_RUN_OUT        <= 1'b1;
            PERIPH_RUN_OUT     <= '0;
            MODE_OUT           <= pmc_pkg::MODE_ACTIVE;
            RDATA_OUT          <= 8'h00;
        end else begin
            CORE_RUN_OUT       <= gate_nxt.core_run;
            OSC_RUN_OUT        <= gate_nxt.osc_run;
            SYSTEM_CLOCK_RUN_OUT     <= gate_nxt.system_clock_run;
            TIMERS_IRQ_RUN_OUT <= gate_nxt.timers_irq_run;
            ADC_RUN_OUT        <= gate_nxt.adc_run;
            PERIPH_RUN_OUT     <= gate_nxt.periph_run[NPERIPH-1:0];
            MODE_OUT           <= mode_nxt;
            RDATA_OUT          <= RD_IN ? rd_mux : 8'h00;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_stop_req;
        mode_r == pmc_pkg::MODE_ACTIVE && pwr_ctrl_r[pmc_pkg::STOP_BIT];
    endsequence
    sequence s_idle_req;
        mode_r == pmc_pkg::MODE_ACTIVE && pwr_ctrl_r[pmc_pkg::IDLE_BIT] &&
        !pwr_ctrl_r[pmc_pkg::STOP_BIT] && !osc_ctrl_r[pmc_pkg::SUSPEND_BIT];
    endsequence

    a_active_core_run: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        mode_r == pmc_pkg::MODE_ACTIVE && !$past(DEBUG_HALT_IN) && !$past(RST_IN)
        |-> CORE_RUN_OUT && OSC_RUN_OUT) else $error("core not running in active");
    a_idle_entry: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        s_idle_req |=> !CORE_RUN_OUT && SYSTEM_CLOCK_RUN_OUT && MODE_OUT == 2'h1)
        else $error("idle entry wrong");
    a_lowpwr_gates: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (mode_r == pmc_pkg::MODE_SUSPEND || mode_r == pmc_pkg::MODE_STOP) &&
        !$past(RST_IN) |-> !CORE_RUN_OUT && !OSC_RUN_OUT && !TIMERS_IRQ_RUN_OUT)
        else $error("low power gating wrong");
    a_suspend_intclk: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        mode_nxt == pmc_pkg::MODE_SUSPEND && int_clk_src |=> PERIPH_RUN_OUT == '0 &&
        !SYSTEM_CLOCK_RUN_OUT) else $error("suspend peripherals not stopped");
    a_suspend_wake: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        mode_r == pmc_pkg::MODE_SUSPEND && suspend_wake |=> mode_r == pmc_pkg::MODE_ACTIVE)
        else $error("suspend wake missed");
    a_stop_sticky: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        s_stop_req |=> (mode_r == pmc_pkg::MODE_STOP) [*4]) else $error("stop exited");
    a_debug_stall: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        DEBUG_HALT_IN && mode_nxt == pmc_pkg::MODE_ACTIVE |=> PERIPH_RUN_OUT == '0 &&
        ADC_RUN_OUT) else $error("debug stall wrong");
    a_idle_autoclr: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        idle_exit && !wr_pwr |=> !pwr_ctrl_r[pmc_pkg::IDLE_BIT] &&
        mode_r == pmc_pkg::MODE_ACTIVE) else $error("idle bit not cleared");
endmodule // power_mode_controller

// ---- shared/pmc_pkg.sv ----
package pmc_pkg;
    localparam logic [7:0] ADDR_POWER_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OSC_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_PERIPH_EN  = 8'h08;
    localparam logic [7:0] ADDR_MODE_STAT  = 8'h0C;
    localparam int         IDLE_BIT        = 0;
    localparam int         STOP_BIT        = 1;
    localparam int         SUSPEND_BIT     = 5;
    localparam int         CLKSRC_BIT      = 0;
    localparam int         CMP0_EN_BIT     = 7;
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam int         SYNC_STAGES     = 2;

    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_IDLE,
        MODE_SUSPEND,
        MODE_STOP
    } mode_code_t;

    typedef struct packed {
        logic port0_match;
        logic port1_match;
        logic cmp0_enabled;
        logic cmp0_out;
    } wake_src_t;

    typedef struct packed {
        logic core_run;
        logic osc_run;
        logic system_clock_run;
        logic timers_irq_run;
        logic adc_run;
        logic [7:0] periph_run;
    } gate_t;
endpackage

// ---- src/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;

    // Two stages; the first is read only by the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= '0;
            q_out  <= '0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule // pin_sync

// ---- sim/power_mode_controller_tb.sv ----
`timescale 1ns/1ps
module power_mode_controller_tb;
    typedef struct packed {
        logic        is_rd;
        logic [14:0] exp;
        logic [14:0] mask;
    } note_t;
    localparam logic [14:0] FULL = 15'h7FFF;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        irq = 1'b0;
    logic        dbg = 1'b0;
    logic        p0 = 1'b0;
    logic        p1 = 1'b0;
    logic        cmp = 1'b1;
    logic        probe = 1'b0;
    logic        rd_q = 1'b0;
    logic [7:0]  rdata;
    logic [7:0]  prun;
    logic [1:0]  mode;
    logic        core, osc, sclk, tmr, adc;
    logic [14:0] obs;
    logic [7:0]  en;
    logic [31:0] seed = 32'h107024B5;
    int          fails = 0;
    int          checks_done = 0;
    int          cycles = 0;
    note_t       notes[$];
    note_t       n;

    assign obs = {mode, core, osc, sclk, tmr, adc, prun};
    always #5 clk = ~clk;

    power_mode_controller #(.NPERIPH(8)) i_dut (
        .SYS_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_PENDING_IN(irq),
        .DEBUG_HALT_IN(dbg), .PORT0_MATCH_IN(p0), .PORT1_MATCH_IN(p1),
        .CMP0_OUT_IN(cmp), .CORE_RUN_OUT(core), .OSC_RUN_OUT(osc),
        .SYSTEM_CLOCK_RUN_OUT(sclk), .TIMERS_IRQ_RUN_OUT(tmr), .ADC_RUN_OUT(adc),
        .PERIPH_RUN_OUT(prun), .MODE_OUT(mode));

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic check(input logic [14:0] seen, input logic [14:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        // A note left unconsumed means an expected result never appeared
        if (notes.size() != 0) fails++;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    // One idle cycle after each strobe keeps a signal from being driven twice in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr <= 1'b1; addr <= a; wdata <= d;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] want);
        notes.push_back({1'b1, 7'h00, want, 15'h00FF});
        rd <= 1'b1; addr <= a;
        tick(1);
        rd <= 1'b0;
        tick(1);
    endtask
    task automatic probe_chk(input logic [14:0] want, input logic [14:0] m);
        notes.push_back({1'b0, want, m});
        probe <= 1'b1;
        tick(1);
        probe <= 1'b0;
        tick(1);
    endtask
    task automatic wait_active();
        int k;
        k = 0;
        while (mode !== 2'h0 && k < 10) begin
            tick(1);
            k++;
        end
        if (k == 10) fails++;
    endtask

    // ==========================================
    // Monitor: each result takes the oldest note
    always @(posedge clk) begin
        rd_q <= rd;
        cycles <= cycles + 1;
        if (rd_q || probe) begin
            n = notes.pop_front();
            check((n.is_rd ? {7'h00, rdata} : obs) & n.mask, n.exp & n.mask);
        end
        if (cycles == 2000) begin
            fails++;
            complete_run();
        end
    end

    // ==========================================
    // Stimulus
    initial begin
        tick(2);
        rst <= 1'b0;
        tick(1);
        probe_chk({2'h0, 5'h1F, 8'h00}, FULL);
        wr_reg(8'h10, 8'hFF);
        for (int i = 0; i < 5; i++) rd_reg(8'(i * 4), 8'h00);
        repeat (3) begin
            en = rnd();
            wr_reg(8'h08, en);
            rd_reg(8'h08, en);
            probe_chk({2'h0, 5'h1F, en}, FULL);
        end
        $display("test reset_active done");
        dbg <= 1'b1;
        tick(2);
        probe_chk({2'h0, 5'h0D, 8'h00}, FULL);
        dbg <= 1'b0;
        tick(2);
        probe_chk({2'h0, 5'h1F, en}, FULL);
        $display("test debug done");
        wr_reg(8'h00, 8'h01);
        tick(1);
        probe_chk({2'h1, 5'h0F, en}, FULL);
        rd_reg(8'h0C, 8'h01);
        irq <= 1'b1;
        tick(1);
        irq <= 1'b0;
        tick(2);
        probe_chk({2'h0, 5'h1F, en}, FULL);
        rd_reg(8'h00, 8'h00);
        $display("test idle done");
        // Comparator low but disabled must not wake the first two rounds
        cmp <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                cmp <= 1'b1;
                tick(3);
            end
            en = rnd();
            en[7] = (k == 2);
            wr_reg(8'h08, en);
            wr_reg(8'h04, {7'h10, k == 1});
            tick(5);
            // External clock keeps the system clock, peripherals and ADC alive
            probe_chk({2'h2, (k == 1) ? 5'h05 : 5'h00, (k == 1) ? en : 8'h00},
                      FULL);
            case (k)
                0: p0 <= 1'b1;
                1: p1 <= 1'b1;
                default: cmp <= 1'b0;
            endcase
            wait_active();
            p0 <= 1'b0;
            p1 <= 1'b0;
            probe_chk({2'h0, 5'h1F, en}, FULL);
            rd_reg(8'h04, {7'h00, k == 1});
        end
        $display("test suspend done");
        wr_reg(8'h00, 8'h02);
        tick(1);
        probe_chk({2'h3, 5'h00, 8'h00}, {2'h3, 5'b11110, 8'hFF});
        irq <= 1'b1;
        p0 <= 1'b1;
        tick(6);
        probe_chk({2'h3, 5'h00, 8'h00}, {2'h3, 5'b11110, 8'hFF});
        irq <= 1'b0;
        p0 <= 1'b0;
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        probe_chk({2'h0, 5'h1F, 8'h00}, FULL);
        rd_reg(8'h08, 8'h00);
        $display("test stop done");
        // Let the monitor take the last read before the verdict
        tick(2);
        complete_run();
    end
endmodule // power_mode_controller_tb
